/* shared/acc_load_cfg.svh */
/*
  Constants for the accumulator load decoder: opcodes, widths and reset values.
  Assumes it is included by its bare name from the package and design files.
*/
`ifndef ACC_LOAD_CFG_SVH
`define ACC_LOAD_CFG_SVH

`define INSTR_WIDTH 10
`define ACC_WIDTH 4
`define PTR_EXT_WIDTH 3
`define ACC_TOP_BIT 3
`define OPC_LOAD_ACC_FROM_PTR_EXT 10'h051
`define OPC_LOAD_ACC_FROM_IRQ_CTL_ONE 10'h253
`define OPC_LOAD_ACC_FROM_IRQ_CTL_TWO 10'h254
`define ACC_RESET_DATA 4'h0

`endif

/* shared/acc_load_pkg.sv */
/*
  Types for the accumulator load decoder: decoded operation and accumulator write carrier.
  Assumes acc_load_cfg.svh is on the include path.
*/
`default_nettype none
`include "acc_load_cfg.svh"

package acc_load_pkg;

  typedef enum logic [3:0] {
    OP_NONE = 4'h1,
    OP_PTR_EXT = 4'h2,
    OP_IRQ_ONE = 4'h4,
    OP_IRQ_TWO = 4'h8
  } load_op_t;

  typedef struct packed {
    logic wr_en;
    logic [`ACC_WIDTH-1:0] data;
  } acc_write_t;

endpackage : acc_load_pkg

`default_nettype wire

/* design/accumulator_load_from_regs.sv */
/*
  Decode and execute of the three single-cycle accumulator load instructions.
  Assumes instruction word, strobe and source registers come from core logic on clk.
*/
`default_nettype none
`include "acc_load_cfg.svh"

module accumulator_load_from_regs (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic instr_valid,
  input wire logic [`INSTR_WIDTH-1:0] instr_word,
  input wire logic [`PTR_EXT_WIDTH-1:0] ptr_ext_bits,
  input wire logic [`ACC_WIDTH-1:0] irq_ctl_reg_one,
  input wire logic [`ACC_WIDTH-1:0] irq_ctl_reg_two,
  output acc_load_pkg::acc_write_t acc_write,
  output logic instr_done,
  output logic carry_wr_en,
  output logic skip_req
);

  // Reset synchroniser stages
  logic rst_sync1_reg;
  logic rst_sync1_next;
  logic rst_sync2_reg;
  logic rst_sync2_next;

  // Decoded operation of the word presented this cycle
  acc_load_pkg::load_op_t op;
  logic op_is_load;

  acc_load_pkg::acc_write_t acc_write_reg;
  acc_load_pkg::acc_write_t acc_write_next;

  logic instr_done_reg;
  logic instr_done_next;

  // Side effects these loads never have, still flops so outputs stay clean
  logic carry_wr_en_reg;
  logic carry_wr_en_next;
  logic skip_req_reg;
  logic skip_req_next;

  // Exact match on all ten bits; neighbouring codes fall through to none
  function automatic acc_load_pkg::load_op_t decode_op(input logic [`INSTR_WIDTH-1:0] word);
    case (word)
      `OPC_LOAD_ACC_FROM_PTR_EXT:
      begin
        decode_op = acc_load_pkg::OP_PTR_EXT;
      end
      `OPC_LOAD_ACC_FROM_IRQ_CTL_ONE:
      begin
        decode_op = acc_load_pkg::OP_IRQ_ONE;
      end
      `OPC_LOAD_ACC_FROM_IRQ_CTL_TWO:
      begin
        decode_op = acc_load_pkg::OP_IRQ_TWO;
      end
      default:
      begin
        decode_op = acc_load_pkg::OP_NONE;
      end
    endcase
  endfunction : decode_op

  // Shared by write and completion so the two strobes cannot disagree
  function automatic logic is_load(input acc_load_pkg::load_op_t kind);
    case (kind)
      acc_load_pkg::OP_PTR_EXT:
      begin
        is_load = 1'b1;
      end
      acc_load_pkg::OP_IRQ_ONE:
      begin
        is_load = 1'b1;
      end
      acc_load_pkg::OP_IRQ_TWO:
      begin
        is_load = 1'b1;
      end
      default:
      begin
        is_load = 1'b0;
      end
    endcase
  endfunction : is_load

  // Narrow source is zero-extended; the top bit is cleared, never kept
  function automatic logic [`ACC_WIDTH-1:0] widen_ptr_ext(input logic [`PTR_EXT_WIDTH-1:0] bits);
    logic [`ACC_WIDTH-1:0] word;
    word = {`ACC_WIDTH{1'b0}};
    word[`PTR_EXT_WIDTH-1:0] = bits;
    word[`ACC_TOP_BIT] = 1'b0;
    widen_ptr_ext = word;
  endfunction : widen_ptr_ext

  always_comb
  begin
    rst_sync1_next = 1'b1;
    rst_sync2_next = rst_sync1_reg;
  end

  // Reset released through two flops so removal is synchronous to clk
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end
    else
    begin
      rst_sync1_reg <= rst_sync1_next;
      rst_sync2_reg <= rst_sync2_next;
    end
  end

  // Invalid cycles decode as nothing so a stale word never executes twice
  always_comb
  begin
    op = acc_load_pkg::OP_NONE;
    if (instr_valid)
    begin
      op = decode_op(instr_word);
    end
    op_is_load = is_load(op);
  end

  always_comb
  begin
    acc_write_next.wr_en = op_is_load;
    acc_write_next.data = acc_write_reg.data;
    case (op)
      acc_load_pkg::OP_PTR_EXT:
      begin
        acc_write_next.data = widen_ptr_ext(ptr_ext_bits);
      end
      acc_load_pkg::OP_IRQ_ONE:
      begin
        acc_write_next.data = irq_ctl_reg_one;
      end
      acc_load_pkg::OP_IRQ_TWO:
      begin
        acc_write_next.data = irq_ctl_reg_two;
      end
      default:
      begin
        acc_write_next.data = acc_write_reg.data;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync2_reg)
  begin
    if (!rst_sync2_reg)
    begin
      acc_write_reg <= '{wr_en: 1'b0, data: `ACC_RESET_DATA};
    end
    else
    begin
      acc_write_reg <= acc_write_next;
    end
  end

  always_comb
  begin
    instr_done_next = op_is_load;
  end

  always_ff @(posedge clk or negedge rst_sync2_reg)
  begin
    if (!rst_sync2_reg)
    begin
      instr_done_reg <= 1'b0;
    end
    else
    begin
      instr_done_reg <= instr_done_next;
    end
  end

  // None of these loads touches carry or requests a skip
  always_comb
  begin
    carry_wr_en_next = 1'b0;
  end

  always_ff @(posedge clk or negedge rst_sync2_reg)
  begin
    if (!rst_sync2_reg)
    begin
      carry_wr_en_reg <= 1'b0;
    end
    else
    begin
      carry_wr_en_reg <= carry_wr_en_next;
    end
  end

  always_comb
  begin
    skip_req_next = 1'b0;
  end

  always_ff @(posedge clk or negedge rst_sync2_reg)
  begin
    if (!rst_sync2_reg)
    begin
      skip_req_reg <= 1'b0;
    end
    else
    begin
      skip_req_reg <= skip_req_next;
    end
  end

  // Every output comes straight from a flop
  assign acc_write = acc_write_reg;
  assign instr_done = instr_done_reg;
  assign carry_wr_en = carry_wr_en_reg;
  assign skip_req = skip_req_reg;

endmodule : accumulator_load_from_regs

`default_nettype wire

/* tb/acc_load_chk.sv */
/* Checker for the accumulator load decoder.
   Assumes binding to the top module's ports. */
`default_nettype none
module acc_load_chk (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic instr_valid,
  input wire logic [9:0] instr_word,
  input wire logic [2:0] ptr_ext_bits,
  input wire logic [3:0] irq_ctl_reg_one,
  input wire logic [3:0] irq_ctl_reg_two,
  input wire acc_load_pkg::acc_write_t acc_write,
  input wire logic instr_done,
  input wire logic carry_wr_en,
  input wire logic skip_req
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_ptr_ext_low: assert property (instr_valid && instr_word == 10'h051
    |=> acc_write.wr_en && acc_write.data[2:0] == $past(ptr_ext_bits)) else $error("ptr low bits");
  a_ptr_top_zero: assert property (instr_valid && instr_word == 10'h051
    |=> !acc_write.data[3]) else $error("bit three set");
  a_irq_one_load: assert property (instr_valid && instr_word == 10'h253
    |=> acc_write.wr_en && acc_write.data == $past(irq_ctl_reg_one)) else $error("irq one");
  a_irq_two_load: assert property (instr_valid && instr_word == 10'h254
    |=> acc_write.wr_en && acc_write.data == $past(irq_ctl_reg_two)) else $error("irq two");
  a_done_with_write: assert property (instr_done == acc_write.wr_en) else $error("done");
  a_no_side_effect: assert property (!carry_wr_en && !skip_req) else $error("carry or skip");
  // Ignored words must leave the accumulator alone
  a_ignored_hold: assert property (!(instr_valid && instr_word inside {10'h051, 10'h253, 10'h254})
    |=> !acc_write.wr_en && $stable(acc_write.data)) else $error("stray write");
endmodule : acc_load_chk
bind accumulator_load_from_regs acc_load_chk i_chk (
  .clk(clk),
  .reset_n(reset_n),
  .instr_valid(instr_valid),
  .instr_word(instr_word),
  .ptr_ext_bits(ptr_ext_bits),
  .irq_ctl_reg_one(irq_ctl_reg_one),
  .irq_ctl_reg_two(irq_ctl_reg_two),
  .acc_write(acc_write),
  .instr_done(instr_done),
  .carry_wr_en(carry_wr_en),
  .skip_req(skip_req)
);
`default_nettype wire

/* tb/accumulator_load_from_regs_tb_top.sv */
/* Random mix of the three loads and ignored words.
   Assumes design, package and checker compiled first. */
`default_nettype none
`define CHK(a, b) comparisons++; if ((a) !== (b)) begin miscompares++; $display("wrong value %0t bad", $time); end
module accumulator_load_from_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, reset_n = 0, instr_valid = 0;
  logic [9:0] instr_word = 0;
  logic [2:0] ptr_ext_bits = 0, p;
  logic [3:0] irq_ctl_reg_one = 0, irq_ctl_reg_two = 0, a, b;
  logic instr_done, carry_wr_en, skip_req, v;
  acc_load_pkg::acc_write_t acc_write;
  logic [3:0] exp_q[$];
  int miscompares = 0, comparisons = 0, k;
  // Last entry is a neighbour code that must be ignored
  logic [9:0] ops[4] = '{10'h051, 10'h253, 10'h254, 10'h255};
  accumulator_load_from_regs i_dut (
    .clk(clk),
    .reset_n(reset_n),
    .instr_valid(instr_valid),
    .instr_word(instr_word),
    .ptr_ext_bits(ptr_ext_bits),
    .irq_ctl_reg_one(irq_ctl_reg_one),
    .irq_ctl_reg_two(irq_ctl_reg_two),
    .acc_write(acc_write),
    .instr_done(instr_done),
    .carry_wr_en(carry_wr_en),
    .skip_req(skip_req)
  );
  always #2 clk = ~clk;
  task results;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results
  initial
  begin
    void'($urandom(72165));
    repeat (4) @(posedge clk);
    reset_n <= 1;
    repeat (3) @(posedge clk);
    repeat (400) @(posedge clk)
    begin
      k = $urandom % 4;
      v = ($urandom % 4) != 0;
      p = 3'($urandom);
      a = 4'($urandom);
      b = 4'($urandom);
      {instr_valid, instr_word, ptr_ext_bits, irq_ctl_reg_one, irq_ctl_reg_two} <= {v, ops[k], p, a, b};
      if (v && k < 3)
        exp_q.push_back(k == 0 ? {1'b0, p} : k == 1 ? a : b);
    end
    // Let the last word be sampled before valid drops
    @(posedge clk);
    instr_valid <= 0;
    repeat (3) @(posedge clk);
    `CHK(exp_q.size(), 0)
    $display("test mixed_loads done");
    results;
  end
  // Sampled off the launching edge so flop updates have landed
  always @(negedge clk)
  begin
    `CHK(instr_done, acc_write.wr_en)
    `CHK({carry_wr_en, skip_req}, 2'b00)
    // An unknown strobe is treated as a write so it cannot slip past
    if (acc_write.wr_en !== 1'b0)
    begin
      `CHK(acc_write.wr_en, 1'b1)
      `CHK(exp_q.size() > 0, 1'b1)
      `CHK(acc_write.data, exp_q.pop_front())
    end
  end
  initial
  begin
    #4000;
    miscompares++;
    results;
  end
endmodule : accumulator_load_from_regs_tb_top
`default_nettype wire
